//--- hdl/sit_timer.sv
// 16-bit interval / square-wave / event timer with its register port
//
// What this block does
// - 16-bit counter steps by one per selected count tick while enabled.
// - counter is neither readable nor writable; reset loads it with zero.
// - counter clears on stop, on match in clear mode, after overflow in free mode.
// - counter compared with compare_value continuously; equality raises match_interrupt in clear mode.
// - compare_value written as one 16-bit unit on the high byte write, whether counting or stopped.
// - bit 7 count_enable: 0 stops and clears counter, 1 starts counting.
// - bit 6: 0 clears on match with interrupt, 1 free-runs without interrupt.
// - bit 5: 0 holds timer output low, 1 lets output flip-flop drive it.
// - bit 4 sets output level shown while enabled and counting stopped.
// - bit 3 read-only, resets 0, inverts on each counter overflow.
// - no overflow detection in clear-on-match mode, so bit 3 stays.
// - bits 1..0 pick main, main/32, main/128 or event rising edge; bit 2 zero.
// - mode_control resets to 00H; single-bit and byte writes both work.
// - first count tick after enabling is ignored; counting starts at the second.
// - compare_value 0000H keeps match_interrupt high while counting in clear mode.
// - output flip-flop inverts on each match, counter clears: 50% square wave.
// - direction bits 3..0: 0 output, 1 input; bits 7..4 read 1; reset FFH.
`timescale 1ns/1ps
`include "sit_regs.svh"

module sit_timer (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// register port
	input  wire sit_pkg::sit_bus_req_t bus_req,
	output      logic [7:0]          rdata,
	// pins
	input  wire logic                event_input_pin,
	output      logic                timer_output_pin,
	output      logic [3:0]          port7_dir_out,
	// event
	output      logic                match_interrupt
);

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------

	// address compare used by both write and read decoding
	function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
		hit = (a == b);
	endfunction

	sit_pkg::sit_state_t s_r;
	sit_pkg::sit_state_t s_nxt;

	logic        tick;
	logic        div32_tick;
	logic        div128_tick;
	logic        evt_rise;
	logic        running;
	logic        match;
	logic        at_top;
	logic [15:0] cnt_inc;

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------

	// the prescaler is free-running so tap phase is unknown to software; this is
	// the documented up-to-one-tick start error
	always_comb begin
		s_nxt       = s_r;
		s_nxt.rdata = 8'h00;
		cnt_inc     = s_r.main_counter + 16'h0001;

		// prescaler taps off the main clock
		s_nxt.prescale = s_r.prescale + 7'h01;
		div32_tick     = (s_r.prescale[`SIT_DIV32_LOG2-1:0] == 5'h1F);
		div128_tick    = (s_r.prescale == 7'h7F);

		// event pin: two-stage synchroniser, edge taken from second stage only
		s_nxt.evt_sync1 = event_input_pin;
		s_nxt.evt_sync2 = s_r.evt_sync1;
		s_nxt.evt_prev  = s_r.evt_sync2;
		evt_rise        = s_r.evt_sync2 & ~s_r.evt_prev;

		// count tick selection
		unique case (s_r.mode.clock_select)
			sit_pkg::SIT_CLK_MAIN:   tick = 1'b1;
			sit_pkg::SIT_CLK_DIV32:  tick = div32_tick;
			sit_pkg::SIT_CLK_DIV128: tick = div128_tick;
			sit_pkg::SIT_CLK_EVENT:  tick = evt_rise;
		endcase

		match   = (s_r.main_counter == s_r.compare_value);
		at_top  = (s_r.main_counter == 16'hFFFF);
		running = s_r.mode.count_enable;

		// counting
		if (!running) begin
			s_nxt.main_counter = 16'h0000;
			s_nxt.arm          = sit_pkg::SIT_ARM_WAIT;
			s_nxt.out_ff       = s_r.mode.output_initial_level;
		end else if (tick) begin
			if (s_r.arm == sit_pkg::SIT_ARM_WAIT) begin
				s_nxt.arm = sit_pkg::SIT_ARM_RUN;
			end else if (!s_r.mode.mode_select) begin
				if (match) begin
					s_nxt.main_counter = 16'h0000;
					s_nxt.out_ff       = ~s_r.out_ff;
				end else begin
					s_nxt.main_counter = cnt_inc;
				end
			end else begin
				// wrap to zero after FFFF; free mode only sees overflow
				s_nxt.main_counter = cnt_inc;
				if (at_top) begin
					s_nxt.mode.overflow_toggle = ~s_r.mode.overflow_toggle;
				end
			end
		end

		// match level; with compare 0000H the counter idles at zero between
		// ticks, so the level stays high and only its first rise is an event
		s_nxt.match_irq = running && !s_nxt.mode.mode_select &&
			(s_nxt.arm == sit_pkg::SIT_ARM_RUN) &&
			(s_nxt.main_counter == s_nxt.compare_value);

		// register writes
		if (bus_req.wr) begin
			if (hit(bus_req.addr, `SIT_MODE_CTRL_ADDR)) begin
				// bit 3 keeps its hardware value, bit 2 stays zero
				s_nxt.mode.count_enable         = bus_req.wdata[`SIT_BIT_ENABLE];
				s_nxt.mode.mode_select          = bus_req.wdata[`SIT_BIT_MODE];
				s_nxt.mode.output_enable_bit    = bus_req.wdata[`SIT_BIT_OUT_EN];
				s_nxt.mode.output_initial_level = bus_req.wdata[`SIT_BIT_LEVEL];
				s_nxt.mode.clock_select         = sit_pkg::sit_clk_sel_t'(bus_req.wdata[1:0]);
			end
			if (hit(bus_req.addr, `SIT_CMP_LO_ADDR)) begin
				s_nxt.cmp_lo_hold = bus_req.wdata;
			end
			// the pair takes effect together on the high byte write
			if (hit(bus_req.addr, `SIT_CMP_HI_ADDR)) begin
				s_nxt.compare_value = {bus_req.wdata, s_r.cmp_lo_hold};
			end
			if (hit(bus_req.addr, `SIT_PORT7_DIR_ADDR)) begin
				s_nxt.port7_dir = bus_req.wdata[3:0];
			end
		end

		// register reads; the counter has no read path
		if (bus_req.rd) begin
			if (hit(bus_req.addr, `SIT_MODE_CTRL_ADDR)) begin
				s_nxt.rdata = s_r.mode;
			end else if (hit(bus_req.addr, `SIT_PORT7_DIR_ADDR)) begin
				s_nxt.rdata = `SIT_PORT7_DIR_FIXED | {4'h0, s_r.port7_dir};
			end else if (hit(bus_req.addr, `SIT_CMP_LO_ADDR)) begin
				s_nxt.rdata = s_r.compare_value[7:0];
			end else if (hit(bus_req.addr, `SIT_CMP_HI_ADDR)) begin
				s_nxt.rdata = s_r.compare_value[15:8];
			end
		end
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------

	// counter and compare content are undefined in the device; zero is used here
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r           <= '0;
			s_r.port7_dir <= 4'hF;
		end else begin
			s_r <= s_nxt;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------

	assign rdata            = s_r.rdata;
	assign timer_output_pin = s_r.mode.output_enable_bit & s_r.out_ff;
	assign port7_dir_out    = s_r.port7_dir;
	assign match_interrupt  = s_r.match_irq;

endmodule

//--- hdl/sit_regs.svh
// register offsets, field positions, reset values and timing counts of the interval timer
`ifndef SIT_REGS_SVH
`define SIT_REGS_SVH

`define SIT_ADDR_W          16
`define SIT_PORT7_DIR_ADDR  16'hFF27
`define SIT_MODE_CTRL_ADDR  16'hFF68
// compare_value has no printed offset; placed beside the mode register
`define SIT_CMP_LO_ADDR     16'hFF6A
`define SIT_CMP_HI_ADDR     16'hFF6B

`define SIT_PORT7_DIR_RST   8'hFF
`define SIT_PORT7_DIR_FIXED 8'hF0
`define SIT_MODE_CTRL_RST   8'h00

`define SIT_BIT_ENABLE      7
`define SIT_BIT_MODE        6
`define SIT_BIT_OUT_EN      5
`define SIT_BIT_LEVEL       4
`define SIT_BIT_OVF         3
`define SIT_BIT_ZERO        2

`define SIT_DIV32_LOG2      5
`define SIT_DIV128_LOG2     7
`define SIT_PRESCALE_W      7

`endif

//--- hdl/sit_pkg.sv
// types of the interval timer
package sit_pkg;

	// count clock choices held in bits 1..0 of mode_control
	typedef enum logic [1:0] {
		SIT_CLK_MAIN   = 2'b00,
		SIT_CLK_DIV32  = 2'b01,
		SIT_CLK_DIV128 = 2'b10,
		SIT_CLK_EVENT  = 2'b11
	} sit_clk_sel_t;

	// arming: first count tick after start is swallowed
	typedef enum logic [0:0] {
		SIT_ARM_WAIT = 1'b0,
		SIT_ARM_RUN  = 1'b1
	} sit_arm_t;

	// mode_control fields
	typedef struct packed {
		logic         count_enable;
		logic         mode_select;
		logic         output_enable_bit;
		logic         output_initial_level;
		logic         overflow_toggle;
		logic         zero_bit;
		sit_clk_sel_t clock_select;
	} sit_mode_t;

	// register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} sit_bus_req_t;

	// whole state of the timer
	typedef struct packed {
		sit_mode_t   mode;
		logic [15:0] compare_value;
		logic [7:0]  cmp_lo_hold;
		logic [3:0]  port7_dir;
		logic [15:0] main_counter;
		logic [6:0]  prescale;
		logic        evt_sync1;
		logic        evt_sync2;
		logic        evt_prev;
		sit_arm_t    arm;
		logic        out_ff;
		logic        match_irq;
		logic [7:0]  rdata;
	} sit_state_t;

endpackage

//--- sim/sit_timer_sva.sv
// port checker of the interval timer
`timescale 1ns/1ps
`include "sit_regs.svh"
module sit_timer_chk (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  arst_n,
	// register port
	input wire sit_pkg::sit_bus_req_t bus_req,
	input wire logic [7:0]            rdata,
	// pins and event
	input wire logic                  event_input_pin,
	input wire logic                  timer_output_pin,
	input wire logic [3:0]            port7_dir_out,
	input wire logic                  match_interrupt
);
	logic [7:0] mode_r;
	logic [1:0] idle_r;
	// shadow of mode_control; idle_r lets the output settle after a write
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_r <= 8'h00;
			idle_r <= 2'h0;
		end else if (bus_req.wr && bus_req.addr == `SIT_MODE_CTRL_ADDR) begin
			mode_r <= bus_req.wdata & 8'hF3;
			idle_r <= 2'h0;
		end else if (idle_r != 2'h3) begin
			idle_r <= idle_r + 2'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	unmapped_read_a: assert property (bus_req.rd && bus_req.addr == 16'hFF69 |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	dir_read_a: assert property (bus_req.rd && bus_req.addr == `SIT_PORT7_DIR_ADDR
		|=> rdata == {4'hF, $past(port7_dir_out)}) else $error("direction read wrong");
	dir_write_a: assert property (bus_req.wr && bus_req.addr == `SIT_PORT7_DIR_ADDR
		|=> port7_dir_out == $past(bus_req.wdata[3:0])) else $error("direction write lost");
	mode_read_a: assert property (bus_req.rd && bus_req.addr == `SIT_MODE_CTRL_ADDR
		|=> (rdata & 8'hF7) == $past(mode_r)) else $error("mode read wrong");
	out_off_a: assert property (!mode_r[5] && idle_r == 2'h3 |-> !timer_output_pin)
		else $error("output not held low");
	out_level_a: assert property (mode_r[7:5] == 3'b001 && idle_r == 2'h3
		|-> timer_output_pin == mode_r[4]) else $error("initial level wrong");
	free_irq_a: assert property (mode_r[7:6] == 2'b11 && idle_r == 2'h3 |-> !match_interrupt)
		else $error("interrupt in free mode");
	sq_toggle_a: assert property ($rose(match_interrupt) && mode_r[7:5] == 3'b101
		&& mode_r[1:0] == 2'b00 |=> $changed(timer_output_pin) ##0 !match_interrupt)
		else $error("match did not toggle output");
endmodule
bind sit_timer sit_timer_chk u_chk (.clk, .arst_n, .bus_req, .rdata, .event_input_pin,
	.timer_output_pin, .port7_dir_out, .match_interrupt);

//--- sim/sit_timer_tb.sv
// self-checking bench of the interval timer
`timescale 1ns/1ps
`include "sit_regs.svh"
module sit_timer_tb;
	logic                  clk = 1'b0;
	logic                  arst_n = 1'b0;
	sit_pkg::sit_bus_req_t bus_req = '0;
	logic                  event_input_pin = 1'b0;
	logic [7:0]            rdata;
	logic                  timer_output_pin;
	logic [3:0]            port7_dir_out;
	logic                  match_interrupt;
	logic [7:0]            rd_v;
	int                    mismatches = 0;
	int                    checks = 0;
	int                    cyc = 0;
	int                    n;
	sit_timer u_dut (.clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
		.event_input_pin(event_input_pin), .timer_output_pin(timer_output_pin),
		.port7_dir_out(port7_dir_out), .match_interrupt(match_interrupt));
	always #20 clk = ~clk;
	// hang guard: the overflow wait dominates the run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req <= '0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [15:0] a);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1 rd_v = rdata;
	endtask
	// edges until the next rise of match_interrupt, bounded
	task automatic rise(output int k);
		logic p;
		k = 0;
		do begin
			p = match_interrupt;
			@(posedge clk);
			#1 k++;
		end while (!(match_interrupt === 1'b1 && p === 1'b0) && k < 2000);
	endtask
	task automatic set_cmp(input logic [15:0] v);
		wr_reg(`SIT_CMP_LO_ADDR, v[7:0]);
		wr_reg(`SIT_CMP_HI_ADDR, v[15:8]);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		rd_reg(`SIT_PORT7_DIR_ADDR);
		chk("dir reset", rd_v, 16'hFF);
		rd_reg(`SIT_MODE_CTRL_ADDR);
		chk("mode reset", rd_v, 16'h00);
		// bit 0 low routes the shared pin to the timer output
		wr_reg(`SIT_PORT7_DIR_ADDR, 8'h0A);
		rd_reg(`SIT_PORT7_DIR_ADDR);
		chk("dir write", rd_v, 16'hFA);
		wr_reg(`SIT_MODE_CTRL_ADDR, 8'hFF);
		rd_reg(`SIT_MODE_CTRL_ADDR);
		chk("fixed bits", rd_v, 16'hF3);
		rd_reg(16'hFF69);
		chk("unmapped", rd_v, 16'h00);
		wr_reg(`SIT_MODE_CTRL_ADDR, 8'h00);
		set_cmp(16'h0003);
		rd_reg(`SIT_CMP_LO_ADDR);
		chk("compare low", rd_v, 16'h03);
		// stopped with output enabled shows the initial level
		wr_reg(`SIT_MODE_CTRL_ADDR, 8'h30);
		repeat (2) @(posedge clk);
		#1 chk("initial level", 16'(timer_output_pin), 16'h1);
		// every prescaler tap: period is (compare + 1) ticks
		for (int s = 0; s < 3; s++) begin
			wr_reg(`SIT_MODE_CTRL_ADDR, 8'h30);
			wr_reg(`SIT_MODE_CTRL_ADDR, 8'hB0 | 8'(s));
			rise(n);
			if (s == 0) chk("first match", 16'(n), 16'd4);
			rise(n);
			chk("period", 16'(n), 16'd4 << (s == 0 ? 0 : 2 * s + 3));
		end
		// event counting: first edge after start is swallowed
		wr_reg(`SIT_MODE_CTRL_ADDR, 8'h00);
		set_cmp(16'h0002);
		wr_reg(`SIT_MODE_CTRL_ADDR, 8'h83);
		for (int i = 0; i < 3; i++) begin
			repeat (8) @(posedge clk);
			event_input_pin <= 1'b1;
			repeat (8) @(posedge clk);
			event_input_pin <= 1'b0;
			repeat (8) @(posedge clk);
			#1 chk("event match", 16'(match_interrupt), 16'(i == 2));
		end
		// zero compare keeps the interrupt high
		wr_reg(`SIT_MODE_CTRL_ADDR, 8'h00);
		set_cmp(16'h0000);
		wr_reg(`SIT_MODE_CTRL_ADDR, 8'h81);
		repeat (300) @(posedge clk);
		#1 chk("zero compare", 16'(match_interrupt), 16'h1);
		// free run past one wrap flips the read-only flag
		wr_reg(`SIT_MODE_CTRL_ADDR, 8'h00);
		set_cmp(16'h0003);
		wr_reg(`SIT_MODE_CTRL_ADDR, 8'hC0);
		repeat (65545) @(posedge clk);
		rd_reg(`SIT_MODE_CTRL_ADDR);
		chk("overflow flag", rd_v, 16'hC8);
		wr_reg(`SIT_MODE_CTRL_ADDR, 8'h00);
		wr_reg(`SIT_MODE_CTRL_ADDR, 8'h80);
		repeat (40) @(posedge clk);
		rd_reg(`SIT_MODE_CTRL_ADDR);
		chk("flag held", rd_v, 16'h88);
		print_verdict();
	end
endmodule
